// File: acs_defs.svh
// Timing counts and reset values for the startup and chop sequencer
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_INIT_WAIT_BASE     16'd256
`define ACS_INIT_WAIT_EXTRA    16'd44
`define ACS_GC_FIRST_EXTRA     16'd44
`define ACS_FAST_RESULTS       2'd2
`define ACS_SINC_PERIODS       2'd3
`define ACS_GC_PERIODS         2'd3
`define ACS_OSR_DEFAULT        16'h0400
`define ACS_SETTLE_CODE_RESET  4'h0
`define ACS_POR_TIME_NS        500000
`define ACS_CLK_PERIOD_NS      5
`define ACS_POR_CYCLES         (`ACS_POR_TIME_NS / `ACS_CLK_PERIOD_NS)
`endif

// File: acs_fifo.sv
// Result FIFO with valid and ready on both sides
`timescale 1ns/100ps
module acs_fifo
   import acs_pkg::*;
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
)
(
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             flush_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("acs_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = mem_reg[rd_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem_reg[wr_reg] <= in_data_i;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else if (flush_i)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= wr_reg + 1'b1;
         if (pop)
            rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: acs_host_model.sv
// Host model that takes words from the result stream
`timescale 1ns/100ps
module acs_host_model
   import acs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        stall_i,
   input  wire logic        result_valid_i,
   input  wire acs_result_s result_i,
   output logic             result_ready_o
);
   acs_result_s q[$];
   int          kept = 0;

   // Stall comes from the bench so the buffer can be made to fill
   assign result_ready_o = !stall_i;

   always @(posedge clk_i)
   begin
      if (nrst_i && result_valid_i === 1'b1 && result_ready_o)
      begin
         q.push_back(result_i);
         if (q.size() > 2)
            kept = kept + 1;
      end
   end
endmodule

// File: acs_pkg.sv
// Types shared by the startup and chop sequencer
package acs_pkg;
   typedef enum logic [5:0] {
      ACS_POR    = 6'b000001,
      ACS_WAIT   = 6'b000010,
      ACS_CONV   = 6'b000100,
      ACS_GCDLY  = 6'b001000,
      ACS_GCCONV = 6'b010000,
      ACS_GCTAIL = 6'b100000
   } acs_state_e;

   typedef struct packed {
      logic        fast_path;
      logic        chop_polarity;
      logic [15:0] seq;
   } acs_result_s;
endpackage

// File: acs_seq.sv
// Startup, continuous conversion and global-chop sequencer
// Summary of operation
// - Data-ready rises after power-on settling interval
// - Serial traffic ignored until first data-ready rise
// - Modulators wait 256+44 periods after clock
// - Modulator data feeds both filter paths
// - Fast path one period, sinc3 three
// - First two results fast, then sinc3
// - First result 1324, settled 3372 periods
// - Command or pin reset skips power-on wait
// - Continuous mode: result every OVERSAMPLING_RATIO periods
// - Chop alternates polarity, averages consecutive pairs
// - Filter reset on each polarity swap
// - Settle delay after swap, 2 to 65536
// - Chop conversion: delay plus three OVERSAMPLING_RATIO
// - Sync fall or OVERSAMPLING_RATIO change restarts chop
// - First chop result: twice period plus 44
// - Phase calibration bypassed while chop enabled
// - DC test signal invalid under chop
`timescale 1ns/100ps
`include "acs_defs.svh"
module acs_seq
   import acs_pkg::*;
#(
   parameter int OSR_W      = 16,
   parameter int POR_CYCLES = `ACS_POR_CYCLES,
   parameter int FIFO_DEPTH = 4
)
(
   input  wire logic                  clk_i,
   input  wire logic                  nrst_i,
   input  wire logic                  master_clock_input_i,
   input  wire logic                  sync_reset_n_i,
   input  wire logic                  reset_cmd_i,
   input  wire logic                  chop_enable_bit_i,
   input  wire logic [3:0]            chop_settle_delay_code_i,
   input  wire logic [OSR_W-1:0]      oversampling_ratio_i,
   input  wire logic                  dc_test_select_i,
   input  wire logic                  result_ready_i,
   output logic                       conversion_ready_n_o,
   output logic                       serial_accept_o,
   output logic                       modulator_run_o,
   output logic                       fast_path_en_o,
   output logic                       sinc3_path_en_o,
   output logic                       filter_reset_o,
   output logic                       chop_polarity_o,
   output logic                       chop_average_o,
   output logic                       phase_cal_bypass_o,
   output logic                       dc_test_valid_o,
   output logic                       result_valid_o,
   output acs_result_s                result_o,
   output logic                       overflow_o
);
   initial
   begin
      if (OSR_W < 8 || OSR_W > 24)
         $error("acs_seq: OSR_W out of range");
      if (POR_CYCLES < 1)
         $error("acs_seq: POR_CYCLES must be positive");
   end

   localparam int CW = 24;

   // Reset release through two flops
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // Pins from outside the clock domain
   logic mclk_s;
   logic sync_s;
   acs_sync2 #(.RST_VAL(0)) u_sync_mclk
   (
      .clk_i  (clk_i),
      .nrst_i (rst_n_reg),
      .d_i    (master_clock_input_i),
      .q_o    (mclk_s)
   );
   acs_sync2 #(.RST_VAL(1)) u_sync_rst
   (
      .clk_i  (clk_i),
      .nrst_i (rst_n_reg),
      .d_i    (sync_reset_n_i),
      .q_o    (sync_s)
   );

   logic mclk_d_reg;
   logic sync_d_reg;
   logic mod_tick;
   logic sync_fall;
   logic sync_rise;
   always_ff @(posedge clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         mclk_d_reg <= 1'b0;
         sync_d_reg <= 1'b1;
      end
      else
      begin
         mclk_d_reg <= mclk_s;
         sync_d_reg <= sync_s;
      end
   end
   // One modulator period per master clock rising edge
   assign mod_tick  = mclk_s && !mclk_d_reg;
   assign sync_fall = !sync_s && sync_d_reg;
   assign sync_rise = sync_s && !sync_d_reg;

   // Power-on settling timer; only a power-on reset runs it
   logic [31:0] por_cnt_reg;
   logic        por_done_reg;
   always_ff @(posedge clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         por_cnt_reg  <= '0;
         por_done_reg <= 1'b0;
      end
      else if (!por_done_reg)
      begin
         por_cnt_reg <= por_cnt_reg + 32'd1;
         if (por_cnt_reg >= 32'(POR_CYCLES - 1))
            por_done_reg <= 1'b1;
      end
   end

   // OVERSAMPLING_RATIO change and reset command delayed two clocks to line up with synchronised ticks,
   // else a tick already inside the synchroniser counts toward the new run
   logic [OSR_W-1:0] osr_reg;
   logic [1:0]       osr_chg_reg;
   logic [1:0]       cmd_rst_reg;
   logic             osr_change;
   always_ff @(posedge clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         osr_reg     <= OSR_W'(`ACS_OSR_DEFAULT);
         osr_chg_reg <= 2'h0;
         cmd_rst_reg <= 2'h0;
      end
      else
      begin
         osr_reg     <= oversampling_ratio_i;
         osr_chg_reg <= {osr_chg_reg[0], osr_reg != oversampling_ratio_i};
         cmd_rst_reg <= {cmd_rst_reg[0], reset_cmd_i};
      end
   end
   assign osr_change = osr_chg_reg[1];

   // Settle delay 2^(k+1) modulator periods; shift amount widened so code 15 gives 65536
   logic [CW-1:0] settle_dly;
   assign settle_dly = CW'(1) << (5'(chop_settle_delay_code_i) + 5'h01);

   // Soft reset: command, or sync pin held low (released on rise)
   logic soft_rst;
   assign soft_rst = cmd_rst_reg[1] || !sync_s;

   acs_state_e    state_reg;
   logic [CW-1:0] cnt_reg;
   logic [1:0]    res_cnt_reg;
   logic [1:0]    gc_phase_reg;
   logic          gc_first_reg;
   logic          pol_reg;
   logic          emit;
   logic          started_reg;

   // Main sequencer; counts advance on modulator ticks only
   always_ff @(posedge clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         state_reg    <= ACS_POR;
         cnt_reg      <= '0;
         res_cnt_reg  <= '0;
         gc_phase_reg <= '0;
         gc_first_reg <= 1'b1;
         pol_reg      <= 1'b0;
      end
      else if (por_done_reg && (soft_rst || (started_reg && !chop_enable_bit_i
               && state_reg != ACS_CONV && state_reg != ACS_WAIT)))
      begin
         state_reg    <= ACS_WAIT;
         cnt_reg      <= '0;
         res_cnt_reg  <= '0;
         gc_phase_reg <= '0;
         gc_first_reg <= 1'b1;
         pol_reg      <= 1'b0;
      end
      else if (chop_enable_bit_i && started_reg && (sync_fall || osr_change)
               && state_reg != ACS_WAIT)
      begin
         state_reg    <= ACS_GCDLY;
         cnt_reg      <= '0;
         gc_phase_reg <= '0;
         gc_first_reg <= 1'b1;
         pol_reg      <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            ACS_POR:
            begin
               if (por_done_reg)
                  state_reg <= ACS_WAIT;
            end
            ACS_WAIT:
            begin
               if (mod_tick)
               begin
                  cnt_reg <= cnt_reg + CW'(1);
                  if (cnt_reg == CW'(`ACS_INIT_WAIT_BASE + `ACS_INIT_WAIT_EXTRA - 16'd1))
                  begin
                     cnt_reg   <= '0;
                     state_reg <= chop_enable_bit_i ? ACS_GCDLY : ACS_CONV;
                  end
               end
            end
            ACS_CONV:
            begin
               if (chop_enable_bit_i)
               begin
                  state_reg    <= ACS_GCDLY;
                  cnt_reg      <= '0;
                  gc_first_reg <= 1'b1;
               end
               else if (mod_tick)
               begin
                  cnt_reg <= cnt_reg + CW'(1);
                  if (cnt_reg == CW'(osr_reg) - CW'(1))
                  begin
                     cnt_reg <= '0;
                     if (res_cnt_reg != `ACS_FAST_RESULTS)
                        res_cnt_reg <= res_cnt_reg + 2'd1;
                  end
               end
            end
            ACS_GCDLY:
            begin
               if (mod_tick)
               begin
                  cnt_reg <= cnt_reg + CW'(1);
                  if (cnt_reg == settle_dly - CW'(1))
                  begin
                     cnt_reg      <= '0;
                     gc_phase_reg <= '0;
                     state_reg    <= ACS_GCCONV;
                  end
               end
            end
            ACS_GCCONV:
            begin
               if (mod_tick)
               begin
                  cnt_reg <= cnt_reg + CW'(1);
                  if (cnt_reg == CW'(osr_reg) - CW'(1))
                  begin
                     cnt_reg      <= '0;
                     gc_phase_reg <= gc_phase_reg + 2'd1;
                     if (gc_phase_reg == `ACS_GC_PERIODS - 2'd1)
                     begin
                        pol_reg <= !pol_reg;
                        if (gc_first_reg && !pol_reg)
                           state_reg <= ACS_GCDLY;
                        else if (gc_first_reg)
                           state_reg <= ACS_GCTAIL;
                        else
                           state_reg <= ACS_GCDLY;
                     end
                  end
               end
            end
            ACS_GCTAIL:
            begin
               if (mod_tick)
               begin
                  cnt_reg <= cnt_reg + CW'(1);
                  if (cnt_reg == CW'(`ACS_GC_FIRST_EXTRA) - CW'(1))
                  begin
                     cnt_reg      <= '0;
                     gc_first_reg <= 1'b0;
                     state_reg    <= ACS_GCDLY;
                  end
               end
            end
         endcase
      end
   end

   // Result events
   logic conv_done;
   logic gc_done;
   assign conv_done = (state_reg == ACS_CONV) && mod_tick && !chop_enable_bit_i
                      && (cnt_reg == CW'(osr_reg) - CW'(1));
   assign gc_done = mod_tick && (((state_reg == ACS_GCCONV) && !gc_first_reg
                    && (gc_phase_reg == `ACS_GC_PERIODS - 2'd1)
                    && (cnt_reg == CW'(osr_reg) - CW'(1)))
                    || ((state_reg == ACS_GCTAIL)
                    && (cnt_reg == CW'(`ACS_GC_FIRST_EXTRA) - CW'(1))));
   assign emit = conv_done || gc_done;

   // Path controls and data-ready
   logic [15:0] seq_reg;
   logic        fifo_in_ready;
   always_ff @(posedge clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         started_reg          <= 1'b0;
         conversion_ready_n_o <= 1'b0;
         serial_accept_o      <= 1'b0;
         modulator_run_o      <= 1'b0;
         fast_path_en_o       <= 1'b0;
         sinc3_path_en_o      <= 1'b0;
         filter_reset_o       <= 1'b1;
         chop_polarity_o      <= 1'b0;
         chop_average_o       <= 1'b0;
         phase_cal_bypass_o   <= 1'b0;
         dc_test_valid_o      <= 1'b0;
         seq_reg              <= '0;
         overflow_o           <= 1'b0;
      end
      else
      begin
         if (por_done_reg && !started_reg)
         begin
            started_reg          <= 1'b1;
            conversion_ready_n_o <= 1'b1;
            serial_accept_o      <= 1'b1;
         end
         else if (emit)
            conversion_ready_n_o <= 1'b0;
         else if (mod_tick)
            conversion_ready_n_o <= 1'b1;
         if (sync_rise && started_reg)
            conversion_ready_n_o <= 1'b1;
         modulator_run_o <= (state_reg != ACS_POR) && (state_reg != ACS_WAIT);
         // Both paths run side by side in ACS_CONV only; fast path drops after two results, chop runs sinc3 alone
         sinc3_path_en_o <= (state_reg != ACS_POR) && (state_reg != ACS_WAIT);
         fast_path_en_o  <= (state_reg == ACS_CONV) && (res_cnt_reg != `ACS_FAST_RESULTS)
                            && !chop_enable_bit_i;
         filter_reset_o  <= (state_reg != ACS_GCCONV) && (state_reg != ACS_CONV);
         chop_polarity_o <= pol_reg;
         chop_average_o  <= chop_enable_bit_i;
         phase_cal_bypass_o <= chop_enable_bit_i;
         dc_test_valid_o <= dc_test_select_i && !chop_enable_bit_i;
         if (emit)
            seq_reg <= seq_reg + 16'd1;
         // Full FIFO drops the new result rather than stalling conversion timing
         overflow_o <= emit && !fifo_in_ready;
      end
   end

   acs_result_s fifo_in;
   acs_result_s fifo_out;
   logic        fifo_valid;
   assign fifo_in.fast_path     = fast_path_en_o;
   assign fifo_in.chop_polarity = pol_reg;
   assign fifo_in.seq           = seq_reg;

   acs_fifo #(.WIDTH($bits(acs_result_s)), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_i       (clk_i),
      .nrst_i      (rst_n_reg),
      .flush_i     (soft_rst),
      .in_data_i   (fifo_in),
      .in_valid_i  (emit),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out),
      .out_valid_o (fifo_valid),
      .out_ready_i (result_ready_i && result_valid_o)
   );

   // Registered output stage
   always_ff @(posedge clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         result_valid_o <= 1'b0;
         result_o       <= '0;
      end
      else
      begin
         result_valid_o <= fifo_valid && !(result_ready_i && result_valid_o);
         result_o       <= fifo_out;
      end
   end
endmodule

// File: acs_seq_asserts.sv
// Port checker for the startup and chop sequencer
`timescale 1ns/100ps
module acs_seq_asserts
   import acs_pkg::*;
#(
   parameter int POR_CYCLES = 20
)
(
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        chop_enable_bit_i,
   input wire logic        dc_test_select_i,
   input wire logic        result_ready_i,
   input wire logic        conversion_ready_n_o,
   input wire logic        serial_accept_o,
   input wire logic        fast_path_en_o,
   input wire logic        filter_reset_o,
   input wire logic        chop_polarity_o,
   input wire logic        chop_average_o,
   input wire logic        phase_cal_bypass_o,
   input wire logic        dc_test_valid_o,
   input wire logic        result_valid_o,
   input wire acs_result_s result_o,
   input wire logic        overflow_o
);
   int unsigned up_cnt;

   // Saturates so a long run cannot wrap it
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         up_cnt <= 0;
      else if (up_cnt <= POR_CYCLES)
         up_cnt <= up_cnt + 1;
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_por_wait;
      $rose(serial_accept_o) |-> up_cnt >= POR_CYCLES;
   endproperty
   a_por_wait: assert property (p_por_wait) else $error("ready rose early");
   property p_accept;
      $rose(serial_accept_o) |-> conversion_ready_n_o;
   endproperty
   a_accept: assert property (p_accept) else $error("accept before ready");
   property p_ready_low;
      $fell(conversion_ready_n_o) |=> !conversion_ready_n_o [*3];
   endproperty
   a_ready_low: assert property (p_ready_low) else $error("ready pulse short");
   property p_word_paired;
      $rose(result_valid_o) && !$past(result_valid_o, 2) |-> !conversion_ready_n_o;
   endproperty
   a_word_paired: assert property (p_word_paired) else $error("word without ready");
   property p_hold;
      result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_o);
   endproperty
   a_hold: assert property (p_hold) else $error("word lost while stalled");
   property p_bypass;
      chop_enable_bit_i [*2] |-> phase_cal_bypass_o && chop_average_o;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass missing");
   property p_dc_test;
      dc_test_valid_o |-> !$past(chop_enable_bit_i) && $past(dc_test_select_i);
   endproperty
   a_dc_test: assert property (p_dc_test) else $error("dc test valid in chop");
   property p_swap;
      chop_enable_bit_i && $past(chop_enable_bit_i) && $changed(chop_polarity_o)
         |-> filter_reset_o || $past(filter_reset_o);
   endproperty
   a_swap: assert property (p_swap) else $error("swap without filter reset");
   property p_overflow;
      overflow_o |-> $past(result_valid_o) && !$past(result_ready_i);
   endproperty
   a_overflow: assert property (p_overflow) else $error("drop with room");

   c_chop_word: cover property ($fell(conversion_ready_n_o) && chop_polarity_o);
   c_overflow: cover property (overflow_o);
   c_fast_done: cover property ($fell(fast_path_en_o));
endmodule

bind acs_seq acs_seq_asserts #(.POR_CYCLES(POR_CYCLES)) i_acs_seq_asserts (
   .clk_i, .nrst_i, .chop_enable_bit_i, .dc_test_select_i, .result_ready_i,
   .conversion_ready_n_o, .serial_accept_o, .fast_path_en_o, .filter_reset_o,
   .chop_polarity_o, .chop_average_o, .phase_cal_bypass_o, .dc_test_valid_o,
   .result_valid_o, .result_o, .overflow_o);

// File: acs_seq_tb_top.sv
// Self-checking bench for the startup and chop sequencer
`timescale 1ns/100ps
module acs_seq_tb_top
   import acs_pkg::*;
;
   localparam int POR = 20;
   logic        clk_i, nrst_i, master_clock_input_i, sync_reset_n_i, reset_cmd_i;
   logic        chop_enable_bit_i, dc_test_select_i, result_ready_i;
   logic [3:0]  chop_settle_delay_code_i;
   logic [15:0] oversampling_ratio_i;
   logic        conversion_ready_n_o, serial_accept_o, modulator_run_o, fast_path_en_o;
   logic        sinc3_path_en_o, filter_reset_o, chop_polarity_o, chop_average_o;
   logic        phase_cal_bypass_o, dc_test_valid_o, result_valid_o, overflow_o;
   acs_result_s result_o;
   logic        stall, ovf_seen, mclk_on, tick;
   logic [2:0]  div;
   int          mt, cyc, failures, tests_run;

   acs_seq #(.POR_CYCLES(POR)) i_acs_seq (
      .clk_i, .nrst_i, .master_clock_input_i, .sync_reset_n_i, .reset_cmd_i,
      .chop_enable_bit_i, .chop_settle_delay_code_i, .oversampling_ratio_i,
      .dc_test_select_i, .result_ready_i, .conversion_ready_n_o, .serial_accept_o,
      .modulator_run_o, .fast_path_en_o, .sinc3_path_en_o, .filter_reset_o,
      .chop_polarity_o, .chop_average_o, .phase_cal_bypass_o, .dc_test_valid_o,
      .result_valid_o, .result_o, .overflow_o);
   acs_host_model i_acs_host_model (
      .clk_i, .nrst_i, .stall_i(stall), .result_valid_i(result_valid_o),
      .result_i(result_o), .result_ready_o(result_ready_i));

   initial
   begin
      clk_i = 0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Modulator clock at clk/8, inside the clk/4 limit; mt counts its rises
   always @(posedge clk_i)
   begin
      div <= mclk_on ? div + 3'h1 : 3'h0;
      master_clock_input_i <= mclk_on & div[2];
      tick <= mclk_on & (div == 3'h4);
      mt <= mt + (mclk_on & (div == 3'h4));
      ovf_seen <= ovf_seen | (overflow_o === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         failures = failures + 1;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic wait_ready_n(input logic lvl);
      int n;
      n = 0;
      while (conversion_ready_n_o !== lvl && n < 12000)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(n < 12000, 1);
   endtask

   task automatic next_fall;
      wait_ready_n(1);
      wait_ready_n(0);
   endtask

   // Lands one cycle after a modulator edge, so the sync delay never hides a tick
   task automatic on_tick;
      @(posedge clk_i);
      repeat (8)
         if (tick !== 1)
            @(posedge clk_i);
   endtask

   task automatic t_por;
      int n;
      n = 0;
      @(negedge clk_i);
      chk({conversion_ready_n_o, serial_accept_o, modulator_run_o}, 0);
      while (conversion_ready_n_o !== 1 && n < 200)
      begin
         @(negedge clk_i);
         n++;
      end
      repeat (3) @(negedge clk_i);
      chk({n >= POR && n < 200, serial_accept_o}, 2'h3);
      $display("done: power-on");
   endtask

   task automatic t_start;
      acs_result_s r[$];
      @(posedge clk_i);
      mclk_on <= 1;
      for (int k = 0; k < 3; k++)
      begin
         next_fall();
         chk(mt, 300 + (k + 1) * 1024);
      end
      repeat (4) @(negedge clk_i);
      r = i_acs_host_model.q;
      chk({r[0].fast_path, r[1].fast_path, r[2].fast_path}, 3'h6);
      chk(sinc3_path_en_o, 1);
      chk({modulator_run_o, filter_reset_o}, 2'h2);
      chk(i_acs_host_model.kept, 1);
      $display("done: fast startup");
   endtask

   task automatic t_soft(input bit pin);
      int t0;
      acs_result_s r[$];
      on_tick();
      if (pin)
         sync_reset_n_i <= 0;
      else
         reset_cmd_i <= 1;
      repeat (6) @(posedge clk_i);
      on_tick();
      sync_reset_n_i <= 1;
      reset_cmd_i <= 0;
      t0 = mt;
      i_acs_host_model.q.delete();
      next_fall();
      chk(mt - t0, 300 + oversampling_ratio_i);
      repeat (4) @(negedge clk_i);
      r = i_acs_host_model.q;
      chk(r[0].fast_path, 1);
      $display("done: soft reset %0d", pin);
   endtask

   task automatic t_chop(input logic [3:0] code, input int oversampling_ratio);
      int   t0, d;
      logic p;
      d = 2 << code;
      on_tick();
      chop_enable_bit_i <= 1;
      chop_settle_delay_code_i <= code;
      dc_test_select_i <= 1;
      on_tick();
      oversampling_ratio_i <= oversampling_ratio[15:0];
      t0 = mt;
      next_fall();
      chk(mt - t0, 2 * (d + 3 * oversampling_ratio) + 44);
      p = chop_polarity_o;
      t0 = mt;
      next_fall();
      chk(mt - t0, d + 3 * oversampling_ratio);
      @(negedge clk_i);
      chk({chop_polarity_o ^ p, chop_average_o}, 2'h3);
      chk({phase_cal_bypass_o, dc_test_valid_o}, 2'h2);
      $display("done: chop code %0d", code);
   endtask

   task automatic t_fifo;
      acs_result_s r[$];
      @(posedge clk_i);
      stall <= 1;
      i_acs_host_model.q.delete();
      repeat (5) next_fall();
      repeat (4) @(negedge clk_i);
      chk({ovf_seen, result_valid_o}, 2'h3);
      @(posedge clk_i);
      stall <= 0;
      repeat (8) @(negedge clk_i);
      r = i_acs_host_model.q;
      chk(r.size(), 4);
      chk(r[3].seq - r[0].seq, 3);
      chk(result_valid_o, 0);
      $display("done: result buffer");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      {nrst_i, sync_reset_n_i, reset_cmd_i, chop_enable_bit_i, dc_test_select_i} = 5'h08;
      {stall, ovf_seen, mclk_on, master_clock_input_i, tick} = 5'h00;
      chop_settle_delay_code_i = 4'h0;
      oversampling_ratio_i = 16'h0400;
      {div, mt, cyc, failures, tests_run} = 0;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1;
      t_por();
      t_start();
      t_soft(1);
      t_chop(4'h0, 20);
      t_chop(4'h3, 16);
      @(posedge clk_i);
      chop_enable_bit_i <= 0;
      oversampling_ratio_i <= 16'h0010;
      repeat (3) @(negedge clk_i);
      chk({dc_test_valid_o, phase_cal_bypass_o}, 2'h2);
      t_soft(0);
      t_fifo();
      end_sim();
   end
endmodule

// File: acs_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module acs_sync2
   import acs_pkg::*;
#(
   parameter int RST_VAL = 1
)
(
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_reg;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_reg <= RST_VAL[0];
         q_o      <= RST_VAL[0];
      end
      else
      begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule
